/* hw/dsp_pct_reg.sv */
`timescale 1ns/1ps
module dsp_pct_reg
	import dsp_pkg::*;
#(
	parameter logic [15:0] ADDR = 16'h0000,
	parameter logic [15:0] RESET_VAL = 16'h0064
) (
	input wire logic core_clk,
	input wire logic reset,
	input wire dsp_bus_req_t req,
	output logic [15:0] value,
	output logic hit,
	output logic rejected
);
	logic [15:0] value_reg;
	logic in_range;
	assign hit = (req.addr == ADDR);
	assign in_range = (req.wdata >= DSP_PCT_MIN) && (req.wdata <= DSP_PCT_MAX);
	// Out-of-range writes are dropped so the stored value stays legal
	assign rejected = req.wr && hit && !in_range;
	assign value = value_reg;
	always_ff @(posedge core_clk or posedge reset) begin
		if (reset) begin
			value_reg <= RESET_VAL;
		end else if (req.wr && hit && in_range) begin
			value_reg <= req.wdata;
		end
	end
	property p_in_range;
		@(posedge core_clk) disable iff (reset)
		value_reg >= DSP_PCT_MIN && value_reg <= DSP_PCT_MAX;
	endproperty
	a_in_range: assert property (p_in_range) else $error("pct out of range");
endmodule

/* hw/dsp_pkg.sv */
package dsp_pkg;
	localparam logic [15:0] DSP_ADDR_STAND = 16'h1414;
	localparam logic [15:0] DSP_ADDR_RAMP = 16'h1416;
	localparam logic [15:0] DSP_ADDR_CONST = 16'h1418;
	localparam logic [15:0] DSP_ADDR_ACTION = 16'h1c08;
	localparam logic [15:0] DSP_ADDR_FAULT = 16'h1c0a;
	localparam logic [15:0] DSP_RST_STAND = 16'h0046;
	localparam logic [15:0] DSP_RST_RAMP = 16'h0064;
	localparam logic [15:0] DSP_RST_CONST = 16'h0064;
	localparam logic [15:0] DSP_PCT_MIN = 16'h0001;
	localparam logic [15:0] DSP_PCT_MAX = 16'h0064;
	localparam logic [15:0] DSP_STANDSTILL_RPM = 16'h0009;
	localparam int DSP_BIT_WARN = 0;
	localparam int DSP_BIT_ERR1 = 1;
	localparam int DSP_BIT_STILL = 6;
	localparam int DSP_BIT_CW = 7;
	localparam int DSP_BIT_CCW = 8;
	localparam int DSP_BIT_IDLE = 11;
	localparam int DSP_BIT_DECEL = 12;
	localparam int DSP_BIT_ACCEL = 13;
	localparam int DSP_BIT_CONST = 14;
	typedef enum logic [1:0] {
		DSP_PG_IDLE,
		DSP_PG_ACCEL,
		DSP_PG_DECEL,
		DSP_PG_CONST
	} dsp_pg_state_t;
	typedef struct packed {
		logic wr;
		logic rd;
		logic [15:0] addr;
		logic [15:0] wdata;
	} dsp_bus_req_t;
	typedef struct packed {
		logic warn;
		logic [3:0] err_class;
		logic [15:0] speed_rpm;
		logic dir_ccw;
		dsp_pg_state_t pg_state;
	} dsp_drive_state_t;
endpackage

/* hw/dsp_status_current.sv */
`timescale 1ns/1ps
// What this block does
// - Status bit 0 shows active warning, bits 1-4 show error classes 1-4.
// - Status bit 6 set while measured speed is below 9 rpm.
// - Status bit 7 for clockwise rotation, bit 8 for counter-clockwise.
// - Status bit 11 while profile generator is idle.
// - Status bit 12 while profile generator decelerates.
// - Status bit 13 while profile generator accelerates.
// - Status bit 14 while profile generator moves at constant nonzero speed.
// - Read-only 16-bit register holds error number of last stop fault.
// - Phase current percentage chosen by standstill, ramp or constant motion.
// - Percentage scales so that 100 equals the nominal motor current.
// - Standstill percentage writable 1 to 100, default 70.
// - Ramp percentage writable 1 to 100, default 100.
// - Constant-motion percentage writable 1 to 100, default 100.
module dsp_status_current
	import dsp_pkg::*;
(
	input wire logic core_clk,
	input wire logic reset,
	input wire dsp_bus_req_t bus_req,
	output logic [15:0] bus_rdata,
	output logic bus_ack,
	output logic bus_err,
	input wire dsp_drive_state_t drive,
	input wire logic stop_fault_valid,
	input wire logic [15:0] stop_fault_number,
	input wire logic [15:0] nominal_motor_current,
	output logic [6:0] phase_current_pct,
	output logic [15:0] phase_current_setpoint
);
	logic [15:0] stand_pct;
	logic [15:0] ramp_pct;
	logic [15:0] const_pct;
	logic stand_hit;
	logic ramp_hit;
	logic const_hit;
	logic stand_rej;
	logic ramp_rej;
	logic const_rej;
	logic [15:0] action_word;
	logic [15:0] action_word_reg;
	logic [15:0] fault_reg;
	logic [15:0] rdata_reg;
	logic ack_reg;
	logic err_reg;
	logic standstill;
	logic pg_idle;
	logic pg_decel;
	logic pg_accel;
	logic pg_const;
	logic action_hit;
	logic fault_hit;
	logic any_hit;
	logic ro_write;
	logic wr_rejected;
	logic [15:0] sel_pct;
	logic [15:0] sel_pct_next;
	logic [15:0] pct_reg;
	logic [31:0] product;
	logic [15:0] setpoint_next;
	logic [15:0] setpoint_reg;

	dsp_pct_reg #(.ADDR(DSP_ADDR_STAND), .RESET_VAL(DSP_RST_STAND)) u_stand (
		.core_clk(core_clk),
		.reset(reset),
		.req(bus_req),
		.value(stand_pct),
		.hit(stand_hit),
		.rejected(stand_rej)
	);
	dsp_pct_reg #(.ADDR(DSP_ADDR_RAMP), .RESET_VAL(DSP_RST_RAMP)) u_ramp (
		.core_clk(core_clk),
		.reset(reset),
		.req(bus_req),
		.value(ramp_pct),
		.hit(ramp_hit),
		.rejected(ramp_rej)
	);
	dsp_pct_reg #(.ADDR(DSP_ADDR_CONST), .RESET_VAL(DSP_RST_CONST)) u_const (
		.core_clk(core_clk),
		.reset(reset),
		.req(bus_req),
		.value(const_pct),
		.hit(const_hit),
		.rejected(const_rej)
	);

	assign standstill = drive.speed_rpm < DSP_STANDSTILL_RPM;
	assign pg_idle = drive.pg_state == DSP_PG_IDLE;
	assign pg_decel = drive.pg_state == DSP_PG_DECEL;
	assign pg_accel = drive.pg_state == DSP_PG_ACCEL;
	assign pg_const = drive.pg_state == DSP_PG_CONST;

	always_comb begin
		action_word = 16'h0000;
		action_word[DSP_BIT_WARN] = drive.warn;
		action_word[DSP_BIT_ERR1 +: 4] = drive.err_class;
		action_word[DSP_BIT_STILL] = standstill;
		// Direction bits meaningless at rest, so both clear then
		action_word[DSP_BIT_CW] = !standstill && !drive.dir_ccw;
		action_word[DSP_BIT_CCW] = !standstill && drive.dir_ccw;
		action_word[DSP_BIT_IDLE] = pg_idle;
		action_word[DSP_BIT_DECEL] = pg_decel;
		action_word[DSP_BIT_ACCEL] = pg_accel;
		action_word[DSP_BIT_CONST] = pg_const;
	end

	assign action_hit = bus_req.addr == DSP_ADDR_ACTION;
	assign fault_hit = bus_req.addr == DSP_ADDR_FAULT;
	assign any_hit = stand_hit || ramp_hit || const_hit || action_hit || fault_hit;
	assign ro_write = bus_req.wr && (action_hit || fault_hit);
	assign wr_rejected = stand_rej || ramp_rej || const_rej;

	// Ramp current also covers deceleration; idle uses standstill value
	assign sel_pct_next = pg_idle ? stand_pct : (pg_const ? const_pct : ramp_pct);
	assign sel_pct = pct_reg;
	assign product = pct_reg * nominal_motor_current;
	// Divide by 100 so that 100 percent gives the nominal value exactly
	assign setpoint_next = 16'(product / 32'd100);

	always_ff @(posedge core_clk or posedge reset) begin
		if (reset) begin
			action_word_reg <= 16'h0000;
			fault_reg <= 16'h0000;
			pct_reg <= DSP_RST_STAND;
			setpoint_reg <= 16'h0000;
		end else begin
			action_word_reg <= action_word;
			if (stop_fault_valid) begin
				fault_reg <= stop_fault_number;
			end
			pct_reg <= sel_pct_next;
			setpoint_reg <= setpoint_next;
		end
	end

	always_ff @(posedge core_clk or posedge reset) begin
		if (reset) begin
			rdata_reg <= 16'h0000;
			ack_reg <= 1'b0;
			err_reg <= 1'b0;
		end else begin
			ack_reg <= (bus_req.rd || bus_req.wr) && any_hit && !ro_write && !wr_rejected;
			err_reg <= (bus_req.rd || bus_req.wr) && (!any_hit || ro_write || wr_rejected);
			if (bus_req.rd) begin
				rdata_reg <= stand_hit ? stand_pct :
					ramp_hit ? ramp_pct :
					const_hit ? const_pct :
					action_hit ? action_word_reg :
					fault_hit ? fault_reg : 16'h0000;
			end
		end
	end

	assign bus_rdata = rdata_reg;
	assign bus_ack = ack_reg;
	assign bus_err = err_reg;
	assign phase_current_pct = sel_pct[6:0];
	assign phase_current_setpoint = setpoint_reg;

	property p_standstill;
		@(posedge core_clk) disable iff (reset)
		!reset && drive.speed_rpm < DSP_STANDSTILL_RPM |=> action_word_reg[DSP_BIT_STILL];
	endproperty
	a_standstill: assert property (p_standstill) else $error("standstill bit missing");

	property p_moving;
		@(posedge core_clk) disable iff (reset)
		!reset && drive.speed_rpm >= DSP_STANDSTILL_RPM |=> !action_word_reg[DSP_BIT_STILL];
	endproperty
	a_moving: assert property (p_moving) else $error("standstill bit while moving");

	property p_errors;
		@(posedge core_clk) disable iff (reset)
		!reset |=> action_word_reg[4:0] == {$past(drive.err_class), $past(drive.warn)};
	endproperty
	a_errors: assert property (p_errors) else $error("warning or error bits wrong");

	property p_dir;
		@(posedge core_clk) disable iff (reset)
		!(action_word_reg[DSP_BIT_CW] && action_word_reg[DSP_BIT_CCW]);
	endproperty
	a_dir: assert property (p_dir) else $error("both direction bits set");

	property p_onehot_pg;
		@(posedge core_clk) disable iff (reset)
		!$past(reset) |-> $onehot(action_word_reg[DSP_BIT_CONST:DSP_BIT_IDLE]);
	endproperty
	a_onehot_pg: assert property (p_onehot_pg) else $error("profile bits not one-hot");

	property p_reserved;
		@(posedge core_clk) disable iff (reset)
		action_word_reg[5] == 1'b0 && action_word_reg[10:9] == 2'b00 && !action_word_reg[15];
	endproperty
	a_reserved: assert property (p_reserved) else $error("reserved bit set");

	property p_accel_pct;
		@(posedge core_clk) disable iff (reset)
		(!reset && drive.pg_state == DSP_PG_ACCEL) ##1 (drive.pg_state == DSP_PG_ACCEL)
			|-> pct_reg == $past(ramp_pct);
	endproperty
	a_accel_pct: assert property (p_accel_pct) else $error("ramp current not applied");

	property p_idle_pct;
		@(posedge core_clk) disable iff (reset)
		!reset && pg_idle |=> pct_reg == $past(stand_pct);
	endproperty
	a_idle_pct: assert property (p_idle_pct) else $error("standstill current not applied");

	property p_full_scale;
		@(posedge core_clk) disable iff (reset)
		!reset && pct_reg == DSP_PCT_MAX |=> setpoint_reg == $past(nominal_motor_current);
	endproperty
	a_full_scale: assert property (p_full_scale) else $error("100 percent not nominal");

	property p_fault;
		@(posedge core_clk) disable iff (reset)
		stop_fault_valid |=> fault_reg == $past(stop_fault_number)
			##1 (fault_reg == $past(fault_reg) || $past(stop_fault_valid));
	endproperty
	a_fault: assert property (p_fault) else $error("stop fault number not held");

	property p_reject;
		@(posedge core_clk) disable iff (reset)
		(bus_req.wr && stand_hit && bus_req.wdata > DSP_PCT_MAX)
			|=> bus_err && stand_pct == $past(stand_pct);
	endproperty
	a_reject: assert property (p_reject) else $error("out of range write taken");

	// Reset sampled in the direction, profile-bit and current antecedents: release lands on a clock edge
	property p_cw;
		@(posedge core_clk) disable iff (reset)
		!reset && drive.speed_rpm >= DSP_STANDSTILL_RPM && !drive.dir_ccw
			|=> action_word_reg[DSP_BIT_CW] && !action_word_reg[DSP_BIT_CCW];
	endproperty
	a_cw: assert property (p_cw) else $error("clockwise bit wrong");

	property p_ccw;
		@(posedge core_clk) disable iff (reset)
		!reset && drive.speed_rpm >= DSP_STANDSTILL_RPM && drive.dir_ccw
			|=> action_word_reg[DSP_BIT_CCW] && !action_word_reg[DSP_BIT_CW];
	endproperty
	a_ccw: assert property (p_ccw) else $error("counter-clockwise bit wrong");

	property p_idle_bit;
		@(posedge core_clk) disable iff (reset)
		!reset && drive.pg_state == DSP_PG_IDLE |=> action_word_reg[DSP_BIT_IDLE];
	endproperty
	a_idle_bit: assert property (p_idle_bit) else $error("idle bit missing");

	property p_decel_bit;
		@(posedge core_clk) disable iff (reset)
		!reset && drive.pg_state == DSP_PG_DECEL |=> action_word_reg[DSP_BIT_DECEL];
	endproperty
	a_decel_bit: assert property (p_decel_bit) else $error("decel bit missing");

	property p_accel_bit;
		@(posedge core_clk) disable iff (reset)
		!reset && drive.pg_state == DSP_PG_ACCEL |=> action_word_reg[DSP_BIT_ACCEL];
	endproperty
	a_accel_bit: assert property (p_accel_bit) else $error("accel bit missing");

	property p_const_bit;
		@(posedge core_clk) disable iff (reset)
		!reset && drive.pg_state == DSP_PG_CONST |=> action_word_reg[DSP_BIT_CONST];
	endproperty
	a_const_bit: assert property (p_const_bit) else $error("constant bit missing");

	property p_decel_pct;
		@(posedge core_clk) disable iff (reset)
		!reset && drive.pg_state == DSP_PG_DECEL |=> pct_reg == $past(ramp_pct);
	endproperty
	a_decel_pct: assert property (p_decel_pct) else $error("ramp current not in decel");

	property p_const_pct;
		@(posedge core_clk) disable iff (reset)
		!reset && drive.pg_state == DSP_PG_CONST |=> pct_reg == $past(const_pct);
	endproperty
	a_const_pct: assert property (p_const_pct) else $error("constant current not applied");

	property p_ro_write;
		@(posedge core_clk) disable iff (reset)
		bus_req.wr && (bus_req.addr == DSP_ADDR_ACTION || bus_req.addr == DSP_ADDR_FAULT)
			|=> bus_err && !bus_ack;
	endproperty
	a_ro_write: assert property (p_ro_write) else $error("read-only write accepted");

	property p_pct_reject;
		@(posedge core_clk) disable iff (reset)
		bus_req.wr && (stand_hit || ramp_hit || const_hit)
			&& (bus_req.wdata < DSP_PCT_MIN || bus_req.wdata > DSP_PCT_MAX)
			|=> bus_err && !bus_ack;
	endproperty
	a_pct_reject: assert property (p_pct_reject) else $error("bad pct accepted");

	property p_ramp_write;
		@(posedge core_clk) disable iff (reset)
		bus_req.wr && bus_req.addr == DSP_ADDR_RAMP
			&& bus_req.wdata >= DSP_PCT_MIN && bus_req.wdata <= DSP_PCT_MAX
			|=> bus_ack && ramp_pct == $past(bus_req.wdata);
	endproperty
	a_ramp_write: assert property (p_ramp_write) else $error("ramp write lost");

	property p_fault_read;
		@(posedge core_clk) disable iff (reset)
		bus_req.rd && bus_req.addr == DSP_ADDR_FAULT |=> bus_ack && bus_rdata == $past(fault_reg);
	endproperty
	a_fault_read: assert property (p_fault_read) else $error("fault number read wrong");

	c_accel: cover property (@(posedge core_clk) disable iff (reset) action_word_reg[DSP_BIT_ACCEL]);
	c_decel: cover property (@(posedge core_clk) disable iff (reset) action_word_reg[DSP_BIT_DECEL]);
	c_const: cover property (@(posedge core_clk) disable iff (reset) action_word_reg[DSP_BIT_CONST]);
	c_fault: cover property (@(posedge core_clk) disable iff (reset) stop_fault_valid);
	c_reject: cover property (@(posedge core_clk) disable iff (reset) bus_err);
endmodule

/* tb/drive_status_and_phase_current_tb_top.sv */
`timescale 1ns/1ps
`define CHK(a, e) begin n_checks++; if ((a) !== (e)) begin n_errors++; \
	$display("unexpected at %0t: got %h want %h", $time, (a), (e)); end end
module drive_status_and_phase_current_tb_top;
	import dsp_pkg::*;
	typedef struct packed {logic err; logic chk; logic [15:0] data;} dsp_exp_t;
	localparam logic [15:0] ADDRS [3] = '{DSP_ADDR_STAND, DSP_ADDR_RAMP, DSP_ADDR_CONST};
	logic core_clk = 1'b0;
	logic reset = 1'b1;
	dsp_bus_req_t bus_req;
	logic [15:0] bus_rdata, stop_fault_number, nominal_motor_current, phase_current_setpoint;
	logic bus_ack, bus_err, stop_fault_valid;
	logic [6:0] phase_current_pct;
	dsp_drive_state_t drive;
	dsp_exp_t exp_q [$];
	dsp_exp_t cur;
	int n_errors = 0;
	int n_checks = 0;
	dsp_status_current u_dut (.core_clk(core_clk), .reset(reset), .bus_req(bus_req),
		.bus_rdata(bus_rdata), .bus_ack(bus_ack), .bus_err(bus_err), .drive(drive),
		.stop_fault_valid(stop_fault_valid), .stop_fault_number(stop_fault_number),
		.nominal_motor_current(nominal_motor_current), .phase_current_pct(phase_current_pct),
		.phase_current_setpoint(phase_current_setpoint));
	dsp_master_model u_mst (.core_clk(core_clk), .bus_ack(bus_ack), .bus_err(bus_err),
		.req(bus_req));
	initial forever #5 core_clk = ~core_clk;
	task automatic complete_run();
		$display("checks %0d errors %0d", n_checks, n_errors);
		if (n_errors == 0 && n_checks > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask
	task automatic bus(input logic w, input logic [15:0] a, input logic [15:0] d,
		input logic e, input logic [15:0] x);
		bit ok;
		exp_q.push_back('{err: e, chk: !w && !e, data: x});
		u_mst.xfer(w, a, d, ok);
		if (!ok) begin
			n_errors++;
			$display("unexpected at %0t: bus timeout", $time);
			complete_run();
		end
	endtask
	always @(negedge core_clk) begin
		if (bus_ack === 1'b1 || bus_err === 1'b1) begin
			if (exp_q.size() == 0) begin
				`CHK(1'b1, 1'b0)
			end else begin
				cur = exp_q.pop_front();
				`CHK(bus_err, cur.err)
				if (cur.chk) `CHK(bus_rdata, cur.data)
			end
		end
	end
	initial begin
		logic [15:0] v, x, pv [3];
		logic [31:0] sp;
		logic still;
		dsp_pg_state_t st;
		drive = '{warn: 1'b0, err_class: 4'h0, speed_rpm: 16'h0000, dir_ccw: 1'b0,
			pg_state: DSP_PG_IDLE};
		stop_fault_valid = 1'b0;
		stop_fault_number = 16'h0000;
		nominal_motor_current = 16'h0100;
		pv = '{16'h0046, 16'h0064, 16'h0064};
		v = $urandom(55353);
		repeat (2) @(posedge core_clk);
		reset <= 1'b0;
		`CHK(phase_current_pct, 7'h46)
		for (int i = 0; i < 3; i++) begin
			bus(1'b0, ADDRS[i], 16'h0000, 1'b0, pv[i]);
			bus(1'b1, ADDRS[i], 16'h0000, 1'b1, 16'h0000);
			bus(1'b1, ADDRS[i], 16'h0065, 1'b1, 16'h0000);
			bus(1'b0, ADDRS[i], 16'h0000, 1'b0, pv[i]);
		end
		bus(1'b0, DSP_ADDR_FAULT, 16'h0000, 1'b0, 16'h0000);
		bus(1'b0, DSP_ADDR_ACTION, 16'h0000, 1'b0, 16'h0840);
		bus(1'b1, DSP_ADDR_ACTION, 16'hffff, 1'b1, 16'h0000);
		bus(1'b1, DSP_ADDR_FAULT, 16'h1234, 1'b1, 16'h0000);
		bus(1'b0, 16'h1420, 16'h0000, 1'b1, 16'h0000);
		for (int i = 0; i < 3; i++) begin
			for (int j = 0; j < 3; j++) begin
				pv[i] = (j == 0) ? 16'h0001 : (j == 1) ? 16'h0064 : 16'(1 + $urandom % 100);
				bus(1'b1, ADDRS[i], pv[i], 1'b0, 16'h0000);
				bus(1'b0, ADDRS[i], 16'h0000, 1'b0, pv[i]);
			end
		end
		for (int k = 0; k < 16; k++) begin
			st = dsp_pg_state_t'(k % 4);
			v = (k / 4 == 0) ? 16'h0000 : (k / 4 == 1) ? 16'h0008 :
				(k / 4 == 2) ? 16'h0009 : 16'($urandom);
			@(posedge core_clk);
			drive <= '{warn: 1'($urandom), err_class: 4'($urandom), speed_rpm: v,
				dir_ccw: 1'($urandom), pg_state: st};
			nominal_motor_current <= 16'($urandom);
			stop_fault_valid <= 1'b1;
			stop_fault_number <= 16'($urandom);
			@(posedge core_clk);
			stop_fault_valid <= 1'b0;
			@(negedge core_clk);
			@(negedge core_clk);
			still = v < 16'h0009;
			x = 16'h0000;
			x[0] = drive.warn;
			x[4:1] = drive.err_class;
			x[6] = still;
			x[7] = !drive.dir_ccw && !still;
			x[8] = drive.dir_ccw && !still;
			x[11] = st == DSP_PG_IDLE;
			x[12] = st == DSP_PG_DECEL;
			x[13] = st == DSP_PG_ACCEL;
			x[14] = st == DSP_PG_CONST;
			sp = {16'h0000, pv[(st == DSP_PG_IDLE) ? 0 : (st == DSP_PG_CONST) ? 2 : 1]};
			`CHK(phase_current_pct, sp[6:0])
			sp = (sp * nominal_motor_current) / 100;
			`CHK(phase_current_setpoint, sp[15:0])
			bus(1'b0, DSP_ADDR_ACTION, 16'h0000, 1'b0, x);
			bus(1'b0, DSP_ADDR_FAULT, 16'h0000, 1'b0, stop_fault_number);
		end
		repeat (3) @(posedge core_clk);
		`CHK(exp_q.size(), 0)
		complete_run();
	end
endmodule

/* tb/dsp_master_model.sv */
`timescale 1ns/1ps
module dsp_master_model
	import dsp_pkg::*;
(
	input wire logic core_clk,
	input wire logic bus_ack,
	input wire logic bus_err,
	output dsp_bus_req_t req
);
	initial req = '{wr: 1'b0, rd: 1'b0, addr: 16'h0000, wdata: 16'h0000};
	// Idle lines flip so a stale address or data is never trusted
	task automatic xfer(input logic w, input logic [15:0] a, input logic [15:0] d,
		output bit ok);
		ok = 1'b0;
		@(posedge core_clk);
		req <= '{wr: w, rd: !w, addr: a, wdata: d};
		@(posedge core_clk);
		req <= '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: ~d};
		for (int i = 0; i < 4 && !ok; i++) begin
			@(negedge core_clk);
			ok = (bus_ack === 1'b1) || (bus_err === 1'b1);
		end
	endtask
endmodule
